// File: core/dpr_pkg.sv
// Operation
// - Both ports share 4096 single-bit cells.
// - Width W, address A selects cells A*W upward.
// - Last address 4095/2047/1023/511/255 by width.
// - Simultaneous accesses accepted without arbitration.
// - Conflict only on shared cells with a write.
// - Write-write collision marks stored cells invalid.
// - Colliding writers still show their own input.
// - Read-write collision: write good, reader invalid.
// - Port samples its inputs every rising edge.
// - Enable without write enable performs a read.
// - Enable with write enable stores and mirrors.
// - Enable low: no access, output holds.
// - Other port's write leaves this output alone.
// - Later read returns other port's written value.
// - Sixteen 64-digit init values fill 4096 bits.
// - Segment k fills cells 256k to 256k+255.
// - Missing init segment leaves its cells zero.
// - Short strings zero-pad; over 64 digits rejected.
// - Output reset clears own output, not cells.
// - Address bus 12..8 bits, data equals width.
package dpr_pkg;

    // Size of the shared cell array and of its initialization segments.
    localparam int DPR_CELLS = 4096;
    localparam int DPR_SEGS = 16;
    localparam int DPR_SEG_BITS = 256;
    localparam int DPR_SEG_DIGITS = 64;
    localparam int DPR_DIGIT_BITS = 4;

    // Widest port data bus and widest address bus.
    localparam int DPR_MAX_W = 16;
    localparam int DPR_MAX_ABITS = 12;

    // Reset value of every data output register.
    localparam logic [15:0] DPR_DOUT_RST = 16'h0000;

    typedef logic [DPR_MAX_ABITS-1:0] dpr_addr_t;
    typedef logic [DPR_MAX_W-1:0] dpr_data_t;
    typedef logic [DPR_CELLS-1:0] dpr_cells_t;
    typedef logic [DPR_SEG_BITS-1:0] dpr_seg_t;

    // One port's request as sampled at the clock edge.
    typedef struct packed {
        logic en;
        logic we;
        logic rst;
        dpr_addr_t addr;
        dpr_data_t din;
    } dpr_req_s;

    // One port's answer, held between operations.
    typedef struct packed {
        dpr_data_t dout;
        logic invalid;
    } dpr_rsp_s;

    // Address bus width for a given port width; zero marks an illegal width.
    function automatic int dpr_addr_bits(input int w);
        unique case (w)
            1: return 12;
            2: return 11;
            4: return 10;
            8: return 9;
            16: return 8;
            default: return 0;
        endcase
    endfunction : dpr_addr_bits

    // Highest legal address for a port width.
    function automatic int dpr_last_addr(input int w);
        return (DPR_CELLS / w) - 1;
    endfunction : dpr_last_addr

endpackage : dpr_pkg

// File: core/dpr_port.sv
`timescale 1ns/100ps
// One access port: address mapping, masks toward the array and the output register.
module dpr_port
    import dpr_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input dpr_req_s i_req,
    input dpr_cells_t i_cells,
    input dpr_cells_t i_valid,
    input dpr_cells_t i_other_wr,
    output dpr_rsp_s o_rsp,
    output dpr_cells_t o_acc_mask,
    output dpr_cells_t o_wr_mask,
    output dpr_cells_t o_wr_data
);

    // Address bits beyond the port's bus are ignored, so no address can run past the array.
    localparam int ABITS = dpr_addr_bits(W);
    localparam dpr_addr_t AMASK = dpr_addr_t'((32'h1 << ABITS) - 32'h1);
    localparam dpr_cells_t LOWMASK = {{(DPR_CELLS-W){1'b0}}, {W{1'b1}}};

    wire dpr_addr_t addr_use = i_req.addr & AMASK;
    // The base cell always fits twelve bits because depth times width is constant.
    wire [15:0] base_full = 16'(addr_use) * 16'(W);
    wire [11:0] base = base_full[11:0];

    wire [W-1:0] din_w = i_req.din[W-1:0];
    // Bit j of the word lands on cell base+j for every width.
    wire dpr_cells_t cell_win = LOWMASK << base;
    wire dpr_cells_t rd_shift = i_cells >> base;
    wire dpr_cells_t bad_shift = (~i_valid) >> base;
    wire [W-1:0] rd_w = rd_shift[W-1:0];

    // Decode of the sampled operation.
    wire is_rd = i_req.en & ~i_req.we;
    wire is_wr = i_req.en & i_req.we;

    assign o_acc_mask = i_req.en ? cell_win : '0;
    assign o_wr_mask = is_wr ? cell_win : '0;
    assign o_wr_data = dpr_cells_t'(din_w) << base;

    // A read is untrustworthy if any cell was spoiled or the other port writes it now.
    wire rd_stored_bad = |bad_shift[W-1:0];
    wire rd_clash = |(cell_win & i_other_wr);
    wire rd_bad = rd_stored_bad | rd_clash;

    // Next output: reset wins, a write mirrors its input, a read shows the cells.
    wire dpr_data_t nxt_dout = i_req.rst ? DPR_DOUT_RST :
                               (is_wr ? dpr_data_t'(din_w) : dpr_data_t'(rd_w));
    // A writer's output is never flagged, even when both ports write one cell.
    wire nxt_invalid = ~i_req.rst & is_rd & rd_bad;

    dpr_rsp_s rsp_ff;

    // Output register updates only on this port's own enabled edges.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rsp_ff <= '{dout: DPR_DOUT_RST, invalid: 1'b0};
        end else if (i_req.en) begin
            rsp_ff <= '{dout: nxt_dout, invalid: nxt_invalid};
        end
        // Enable low keeps the last value.
    end

    assign o_rsp = rsp_ff;

endmodule : dpr_port

// File: core/dpr_merge.sv
`timescale 1ns/100ps
// Per-cell merge of both ports' writes into the next array and validity state.
module dpr_merge
    import dpr_pkg::*;
(
    input dpr_cells_t i_cells,
    input dpr_cells_t i_valid,
    input dpr_cells_t i_a_wr,
    input dpr_cells_t i_a_data,
    input dpr_cells_t i_b_wr,
    input dpr_cells_t i_b_data,
    output dpr_cells_t o_cells,
    output dpr_cells_t o_valid
);

    // Each cell is handled alone so that ports of different width mix cleanly.
    for (genvar c = 0; c < DPR_CELLS; c++) begin : g_cell
        wire both = i_a_wr[c] & i_b_wr[c];
        wire any = i_a_wr[c] | i_b_wr[c];
        // Port B data is kept on a double write, but the cell is flagged spoiled anyway.
        assign o_cells[c] = i_b_wr[c] ? i_b_data[c] :
                            (i_a_wr[c] ? i_a_data[c] : i_cells[c]);
        // A single write restores validity; a double write spoils the cell.
        assign o_valid[c] = both ? 1'b0 : (any ? 1'b1 : i_valid[c]);
    end

endmodule : dpr_merge

// File: core/dpr_top.sv
`timescale 1ns/100ps
// Dual-port RAM of 4096 cells with per-port width and configuration-time contents.
module dpr_top
    import dpr_pkg::*;
#(
    parameter int W_A = 16,
    parameter int W_B = 16,
    parameter string INIT_SEG [DPR_SEGS] = '{default: ""}
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input dpr_req_s i_a_req,
    input dpr_req_s i_b_req,
    output dpr_rsp_s o_a_rsp,
    output dpr_rsp_s o_b_rsp,
    output logic o_ww_collision,
    output logic o_rw_collision,
    output logic o_init_err
);

    // Value of one hex digit; anything else counts as zero.
    function automatic logic [3:0] hex_nibble(input byte ch);
        if (ch >= "0" && ch <= "9") begin
            return 4'(ch - "0");
        end else if (ch >= "a" && ch <= "f") begin
            return 4'(ch - "a" + 8'h0a);
        end else if (ch >= "A" && ch <= "F") begin
            return 4'(ch - "A" + 8'h0a);
        end
        return 4'h0;
    endfunction : hex_nibble

    // A short string fills from the low end, leaving the high digits zero.
    function automatic dpr_seg_t seg_value(input string s);
        dpr_seg_t v;
        v = '0;
        if (s.len() > DPR_SEG_DIGITS) begin
            return '0;
        end
        for (int i = 0; i < s.len(); i++) begin
            v = {v[DPR_SEG_BITS-DPR_DIGIT_BITS-1:0], hex_nibble(s[i])};
        end
        return v;
    endfunction : seg_value

    // Segment k lands on cells 256k upward, its last digit on the lowest four cells.
    function automatic dpr_cells_t build_init();
        dpr_cells_t all;
        all = '0;
        for (int k = 0; k < DPR_SEGS; k++) begin
            all[k*DPR_SEG_BITS +: DPR_SEG_BITS] = seg_value(INIT_SEG[k]);
        end
        return all;
    endfunction : build_init

    // Any segment longer than its digit count is a configuration error.
    function automatic logic any_too_long();
        logic bad;
        bad = 1'b0;
        for (int k = 0; k < DPR_SEGS; k++) begin
            bad = bad | (INIT_SEG[k].len() > DPR_SEG_DIGITS);
        end
        return bad;
    endfunction : any_too_long

    localparam dpr_cells_t INIT_CELLS = build_init();
    localparam logic INIT_BAD = any_too_long();

    // Array and per-cell validity; loaded at configuration, never cleared by reset.
    dpr_cells_t mem_ff = INIT_CELLS;
    dpr_cells_t valid_ff = '1;

    wire dpr_cells_t nxt_mem;
    wire dpr_cells_t nxt_valid;

    // Masks that each port presents toward the array.
    wire dpr_cells_t a_acc;
    wire dpr_cells_t a_wr;
    wire dpr_cells_t a_wdata;
    wire dpr_cells_t b_acc;
    wire dpr_cells_t b_wr;
    wire dpr_cells_t b_wdata;

    // Port A; it sees port B's writes to flag its own reads.
    dpr_port #(
        .W(W_A)
    ) u_port_a (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req(i_a_req),
        .i_cells(mem_ff),
        .i_valid(valid_ff),
        .i_other_wr(b_wr),
        .o_rsp(o_a_rsp),
        .o_acc_mask(a_acc),
        .o_wr_mask(a_wr),
        .o_wr_data(a_wdata)
    );

    // Port B, mirror of port A.
    dpr_port #(
        .W(W_B)
    ) u_port_b (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req(i_b_req),
        .i_cells(mem_ff),
        .i_valid(valid_ff),
        .i_other_wr(a_wr),
        .o_rsp(o_b_rsp),
        .o_acc_mask(b_acc),
        .o_wr_mask(b_wr),
        .o_wr_data(b_wdata)
    );

    // Combine both writes cell by cell.
    dpr_merge u_merge (
        .i_cells(mem_ff),
        .i_valid(valid_ff),
        .i_a_wr(a_wr),
        .i_a_data(a_wdata),
        .i_b_wr(b_wr),
        .i_b_data(b_wdata),
        .o_cells(nxt_mem),
        .o_valid(nxt_valid)
    );

    // Both ports share one clock, so a shared cell written by both ports in one edge always breaks the window.
    wire ww_hit = |(a_wr & b_wr);
    wire rw_hit = |((a_acc & ~a_wr & b_wr) | (b_acc & ~b_wr & a_wr));

    // Array update has no reset on purpose; contents survive i_rst like a real block.
    always_ff @(posedge i_clk) begin
        mem_ff <= nxt_mem;
        valid_ff <= nxt_valid;
    end

    logic ww_ff;
    logic rw_ff;

    // Collision indicators pulse for one cycle, in step with the port outputs.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ww_ff <= 1'b0;
            rw_ff <= 1'b0;
        end else begin
            ww_ff <= ww_hit;
            rw_ff <= rw_hit;
        end
    end

    assign o_ww_collision = ww_ff;
    assign o_rw_collision = rw_ff;
    // The user is expected to avoid collisions; these flags only report them.
    assign o_init_err = INIT_BAD;

endmodule : dpr_top

// File: dv/dpr_top_monitor.sv
`timescale 1ns/100ps
// Watches both ports; collision terms are rebuilt here from the requests alone.
module dpr_top_monitor
    import dpr_pkg::*;
#(
    parameter int W_A = 16,
    parameter int W_B = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input dpr_req_s i_a_req,
    input dpr_req_s i_b_req,
    input dpr_rsp_s o_a_rsp,
    input dpr_rsp_s o_b_rsp,
    input wire logic o_ww_collision,
    input wire logic o_rw_collision,
    input wire logic o_init_err
);
    localparam logic [15:0] MA = 16'((17'h1 << W_A) - 1);
    localparam logic [15:0] MB = 16'((17'h1 << W_B) - 1);
    localparam int AMA = (1 << dpr_addr_bits(W_A)) - 1;
    localparam int AMB = (1 << dpr_addr_bits(W_B)) - 1;
    // Only the used address bits count, since upper bits are ignored by the ports.
    int aa;
    int ab;
    assign aa = int'(i_a_req.addr) & AMA;
    assign ab = int'(i_b_req.addr) & AMB;
    // The two words share at least one cell.
    wire ov = (aa * W_A < (ab + 1) * W_B) && (ab * W_B < (aa + 1) * W_A);
    wire wa = i_a_req.en & i_a_req.we;
    wire wb = i_b_req.en & i_b_req.we;
    // A port in output reset still addresses its cells, so it counts as a reader for the flag.
    wire ra = i_a_req.en & ~i_a_req.we;
    wire rb = i_b_req.en & ~i_b_req.we;
    wire ww = wa & wb & ov;
    wire rw = ((wa & rb) | (ra & wb)) & ov;
    // Both ports share the one clock, so a single default clocking covers every check.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_wr_mirror_a: assert property (wa & ~i_a_req.rst |=> !o_a_rsp.invalid &&
        o_a_rsp.dout == ($past(i_a_req.din) & MA)) else $error("port a write not mirrored");
    b_wr_mirror_a: assert property (wb & ~i_b_req.rst |=> !o_b_rsp.invalid &&
        o_b_rsp.dout == ($past(i_b_req.din) & MB)) else $error("port b write not mirrored");
    a_hold_a: assert property (!i_a_req.en |=> $stable(o_a_rsp))
        else $error("a output moved");
    b_hold_a: assert property (!i_b_req.en |=> $stable(o_b_rsp))
        else $error("b output moved");
    out_rst_a: assert property (i_a_req.en & i_a_req.rst |=> o_a_rsp == '0)
        else $error("a output reset failed");
    ww_flag_a: assert property (ww |=> o_ww_collision && !o_a_rsp.invalid &&
        !o_b_rsp.invalid) else $error("write collision handling wrong");
    // A reader held in output reset shows zero, so only a true read is marked invalid.
    rw_flag_a: assert property (wa & rb & ~i_b_req.rst & ov |=>
        o_rw_collision && o_b_rsp.invalid) else $error("read collision handling wrong");
    no_flag_a: assert property (!(ww | rw) |=> !o_ww_collision && !o_rw_collision)
        else $error("collision flag without conflict");
    upper_zero_a: assert property ((o_b_rsp.dout & ~MB) == 16'h0)
        else $error("b output upper bits set");
endmodule : dpr_top_monitor

bind dpr_top dpr_top_monitor #(.W_A(W_A), .W_B(W_B)) i_dpr_top_monitor (.i_clk(i_clk),
    .i_rst(i_rst), .i_a_req(i_a_req), .i_b_req(i_b_req), .o_a_rsp(o_a_rsp),
    .o_b_rsp(o_b_rsp), .o_ww_collision(o_ww_collision), .o_rw_collision(o_rw_collision),
    .o_init_err(o_init_err));

// File: dv/dpr_user.sv
`timescale 1ns/100ps
// User logic for one port: each drive is a one-cycle request launched on the next edge.
module dpr_user
    import dpr_pkg::*;
(
    input wire logic i_clk,
    output dpr_req_s o_req
);
    // Request waiting for the next edge; idle from the start, so en stays low out of reset.
    dpr_req_s pend = '0;
    // Request shown to the port; it only ever changes on a rising edge.
    dpr_req_s req_ff = '0;
    assign o_req = req_ff;
    // Launch on the edge and fall back to idle, so a request is never taken twice.
    always @(posedge i_clk) begin
        req_ff <= pend;
        pend <= '0;
    end
    // Callers keep a written cell clear of the other port unless a collision is wanted.
    task automatic drive(input dpr_req_s r);
        pend = r;
    endtask : drive
endmodule : dpr_user

// File: dv/dpr_top_tb_top.sv
`timescale 1ns/100ps
module dpr_top_tb_top
    import dpr_pkg::*;
;
    // Segment 0 and 15 are short strings; all others stay unset.
    localparam string SEGS [DPR_SEGS] = '{0: "a5c3", 15: "8", default: ""};
    // One segment is a single digit too long, so the configuration error must show.
    localparam string BAD_SEGS [DPR_SEGS] = '{
        2: "00000000000000000000000000000000000000000000000000000000000000001",
        default: ""};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    dpr_req_s a_req;
    dpr_req_s b_req;
    dpr_rsp_s a_rsp;
    dpr_rsp_s b_rsp;
    logic ww;
    logic rw;
    logic ierr;
    logic ierr_bad;
    int failures = 0;
    int n_checks = 0;
    always #25 i_clk = ~i_clk;
    dpr_user i_dpr_user_a (.i_clk(i_clk), .o_req(a_req));
    dpr_user i_dpr_user_b (.i_clk(i_clk), .o_req(b_req));
    // Port A is 16 wide and port B 4 wide, so mixed-width mapping is exercised.
    dpr_top #(.W_A(16), .W_B(4), .INIT_SEG(SEGS)) i_dpr_top (.i_clk(i_clk), .i_rst(i_rst),
        .i_a_req(a_req), .i_b_req(b_req), .o_a_rsp(a_rsp), .o_b_rsp(b_rsp),
        .o_ww_collision(ww), .o_rw_collision(rw), .o_init_err(ierr));
    // Second copy only carries the oversized segment; its ports stay idle throughout.
    dpr_top #(.INIT_SEG(BAD_SEGS)) i_dpr_top_bad (.i_clk(i_clk), .i_rst(i_rst),
        .i_a_req('0), .i_b_req('0), .o_a_rsp(), .o_b_rsp(), .o_ww_collision(),
        .o_rw_collision(), .o_init_err(ierr_bad));
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic dpr_req_s rq(input logic w, input logic r, input int ad, input int d);
        return '{en: 1'b1, we: w, rst: r, addr: 12'(ad), din: 16'(d)};
    endfunction : rq
    function automatic dpr_req_s rd(input int ad);
        return rq(1'b0, 1'b0, ad, 0);
    endfunction : rd
    function automatic dpr_req_s wr(input int ad, input int d);
        return rq(1'b1, 1'b0, ad, d);
    endfunction : wr
    // Both ports launch together; results are looked at just after the taking edge.
    task automatic op(input dpr_req_s a, input dpr_req_s b);
        i_dpr_user_a.drive(a);
        i_dpr_user_b.drive(b);
        repeat (2) @(posedge i_clk);
        #1;
    endtask : op
    // Contents from the segments, and the error flag of the oversized copy.
    task automatic s_init;
        chk(17'(ierr), 17'h0);
        chk(17'(ierr_bad), 17'h1);
        op(rd(0), rd(3));
        chk(a_rsp, {16'ha5c3, 1'b0});
        chk(b_rsp, {16'h000a, 1'b0});
        op(rd(240), rd(4));
        chk(a_rsp, {16'h0008, 1'b0});
        chk(b_rsp, 17'h0);
        op('0, rd(960));
        chk(b_rsp, {16'h0008, 1'b0});
        chk(a_rsp, {16'h0008, 1'b0});
    endtask : s_init
    // Writes on the wide port, read back through the narrow one.
    task automatic s_write;
        op(wr(1, 'h1234), '0);
        chk(a_rsp, {16'h1234, 1'b0});
        chk(b_rsp, {16'h0008, 1'b0});
        op(wr(255, 'hc001), rd(7));
        chk(a_rsp, {16'hc001, 1'b0});
        chk(b_rsp, {16'h0001, 1'b0});
        op('0, rd(1023));
        chk(b_rsp, {16'h000c, 1'b0});
        // Address bits above each port's own bus must be ignored, not wrap past the array.
        op(rd('hf01), rd('hbff));
        chk(a_rsp, {16'h1234, 1'b0});
        chk(b_rsp, {16'h000c, 1'b0});
    endtask : s_write
    // Output reset on A while B writes; the cells must keep both writes.
    task automatic s_rst;
        op(rq(1'b0, 1'b1, 1, 0), wr(4, 'hf));
        chk(a_rsp, 17'h0);
        op(rd(1), '0);
        chk(a_rsp, {16'h123f, 1'b0});
    endtask : s_rst
    // Write on A against a read on B of the same cells in one edge.
    task automatic s_rw;
        op(wr(2, 'hbeef), rd(8));
        chk(a_rsp, {16'hbeef, 1'b0});
        chk(17'(b_rsp.invalid), 17'h1);
        chk(17'(rw), 17'h1);
        op('0, rd(8));
        chk(b_rsp, {16'h000f, 1'b0});
    endtask : s_rw
    // Both ports write shared cells in one edge; those cells must read back as invalid.
    task automatic s_ww;
        op(wr(3, 'h1111), wr(12, 'h7));
        chk(a_rsp, {16'h1111, 1'b0});
        chk(b_rsp, {16'h0007, 1'b0});
        chk(17'(ww), 17'h1);
        op(rd(3), rd(13));
        chk(17'(a_rsp.invalid), 17'h1);
        chk(b_rsp, {16'h0001, 1'b0});
        op(rd(0), rd(0));
        chk(a_rsp, {16'ha5c3, 1'b0});
        chk(b_rsp, {16'h0003, 1'b0});
        chk(17'({ww, rw}), 17'h0);
    endtask : s_ww
    // Mid-run reset clears both outputs but must leave the array as it was.
    task automatic s_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk(a_rsp, 17'h0);
        chk(b_rsp, 17'h0);
        chk(17'({ww, rw}), 17'h0);
        op(rd(1), rd(8));
        chk(a_rsp, {16'h123f, 1'b0});
        chk(b_rsp, {16'h000f, 1'b0});
    endtask : s_reset
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        s_init();
        s_write();
        s_rst();
        s_rw();
        s_ww();
        s_reset();
        end_sim();
    end
    // The tests need about two microseconds; a hang is cut off well after that.
    initial begin
        #20us;
        failures++;
        end_sim();
    end
endmodule : dpr_top_tb_top
